// [hw/pls_loader.sv]
// Program loader: three buttons copy a controller program to a socketed
// EEPROM or back, two lamps report link, transfer and fault states.
// Assumes a byte-wide EEPROM port with one-cycle read latency that raises
// ee_busy in the cycle after a write and holds it until the write is done.
`timescale 1ns/10ps
module pls_loader #(
	parameter logic [pls_pkg::TMR_W-1:0] REPLY_CYC = pls_pkg::REPLY_CYC,
	parameter logic [pls_pkg::TMR_W-1:0] BLINK_CYC = pls_pkg::BLINK_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link
	pls_if.loader lnk,
	// Buttons, high while pressed
	input wire logic program_only_copy_button,
	input wire logic program_and_table_copy_button,
	input wire logic restore_to_controller_button,
	// Lamps
	output logic link_lamp,
	output logic fault_lamp,
	// EEPROM
	input wire logic ee_present,
	input wire logic ee_busy,
	input wire logic [7:0] ee_rdata,
	output logic [pls_pkg::EE_AW-1:0] ee_addr,
	output logic [7:0] ee_wdata,
	output logic ee_we,
	output logic ee_re
);
	localparam int unsigned AW = pls_pkg::EE_AW;
	localparam int unsigned TW = pls_pkg::TMR_W;

	typedef struct packed {
		pls_pkg::pls_ldr_st_e st;
		pls_pkg::pls_ind_e ind;
		logic [TW-1:0] tmr;
		logic [TW-1:0] btmr;
		logic blk;
		logic [2:0] btn;
		logic tbl;
		logic [1:0] ph;
		logic [1:0] sub;
		logic [AW-1:0] ptr;
		logic [AW-1:0] cnt;
		logic [AW-1:0] len;
		logic [6:0] sum;
		logic [6:0] model;
		logic [6:0] hmodel;
		logic go;
		logic [6:0] ch;
		logic we;
		logic re;
		logic [AW-1:0] ea;
		logic [7:0] ed;
		logic link;
		logic fault;
	} pls_ldr_s;

	pls_ldr_s st_r;
	pls_ldr_s st_nxt;
	logic tx_busy;
	logic [6:0] rx_ch;
	logic rx_valid;
	logic rx_perr;
	logic [2:0] btn;
	logic [2:0] pr;
	logic free;
	logic tout;
	logic [AW-1:0] hlen;

	pls_uart u_uart (
		.pclk(pclk),
		.presetn(presetn),
		.tx_ch(st_r.ch),
		.tx_go(st_r.go),
		.tx_busy(tx_busy),
		.txd(lnk.ldr_txd),
		.rxd(lnk.ctl_txd),
		.rx_ch(rx_ch),
		.rx_valid(rx_valid),
		.rx_perr(rx_perr)
	);

	always_comb begin
		st_nxt = st_r;
		st_nxt.go = 1'b0;
		st_nxt.we = 1'b0;
		st_nxt.re = 1'b0;
		btn = {restore_to_controller_button, program_and_table_copy_button,
			program_only_copy_button};
		st_nxt.btn = btn;
		pr = btn & ~st_r.btn;
		free = !tx_busy && !st_r.go;
		tout = st_r.tmr == '0;
		hlen = {ee_rdata[6:0], st_r.len[7:0]};
		st_nxt.tmr = tout ? st_r.tmr : st_r.tmr - 22'h000001;
		if (st_r.btmr == '0) begin
			st_nxt.btmr = BLINK_CYC - 22'h000001;
			st_nxt.blk = !st_r.blk;
		end else begin
			st_nxt.btmr = st_r.btmr - 22'h000001;
		end
		// -----------------------------------------------------------
		// Sequencer
		// -----------------------------------------------------------
		unique case (st_r.st)
			pls_pkg::ST_POLL: begin
				if (free) begin
					st_nxt.go = 1'b1;
					st_nxt.ch = pls_pkg::CH_ENQ;
					st_nxt.tmr = REPLY_CYC;
					st_nxt.st = pls_pkg::ST_ID;
				end
			end
			pls_pkg::ST_ID: begin
				if (rx_valid) begin
					st_nxt.st = pls_pkg::ST_HOLD;
					if (rx_perr) begin
						st_nxt.ind = pls_pkg::IND_COMM;
					end else if (rx_ch >= pls_pkg::MODEL_FIRST && rx_ch <= pls_pkg::MODEL_LAST) begin
						st_nxt.ind = pls_pkg::IND_LINK;
						st_nxt.model = rx_ch;
						st_nxt.tmr = REPLY_CYC;
						st_nxt.st = pls_pkg::ST_READY;
					end else begin
						st_nxt.ind = pls_pkg::IND_FAULT;
					end
				end else if (tout) begin
					st_nxt.ind = pls_pkg::IND_OFF;
					st_nxt.st = pls_pkg::ST_POLL;
				end
			end
			pls_pkg::ST_READY: begin
				if (pr[1:0] != 2'b00) begin
					st_nxt.tbl = pr[1];
					st_nxt.ind = pls_pkg::IND_BUSY;
					st_nxt.st = pls_pkg::ST_UCMD;
				end else if (pr[2]) begin
					st_nxt.ind = pls_pkg::IND_BUSY;
					st_nxt.cnt = '0;
					st_nxt.sub = 2'h0;
					st_nxt.st = pls_pkg::ST_DHDR;
				end else if (tout) begin
					st_nxt.st = pls_pkg::ST_POLL;
				end
			end
			pls_pkg::ST_UCMD: begin
				if (!ee_present) begin
					st_nxt.ind = pls_pkg::IND_FAULT;
					st_nxt.st = pls_pkg::ST_HOLD;
				end else if (free) begin
					st_nxt.go = 1'b1;
					st_nxt.ch = st_r.tbl ? pls_pkg::CMD_UPT : pls_pkg::CMD_UPL;
					st_nxt.ptr = pls_pkg::PROG_BASE;
					st_nxt.cnt = '0;
					st_nxt.sum = '0;
					st_nxt.ph = 2'h0;
					st_nxt.tmr = REPLY_CYC;
					st_nxt.st = pls_pkg::ST_URX;
				end
			end
			pls_pkg::ST_URX: begin
				if (rx_valid) begin
					st_nxt.tmr = REPLY_CYC;
					if (rx_perr) begin
						st_nxt.ind = pls_pkg::IND_COMM;
						st_nxt.st = pls_pkg::ST_HOLD;
					end else if (st_r.ph == 2'h2) begin
						if (rx_ch == st_r.sum) begin
							st_nxt.cnt = '0;
							st_nxt.st = pls_pkg::ST_UHDR;
						end else begin
							st_nxt.ind = pls_pkg::IND_FAULT;
							st_nxt.st = pls_pkg::ST_HOLD;
						end
					end else if (st_r.ph == 2'h0 && rx_ch == pls_pkg::CH_ETX) begin
						st_nxt.len = st_r.cnt;
						st_nxt.cnt = '0;
						st_nxt.ptr = pls_pkg::TBL_BASE;
						st_nxt.ph = st_r.tbl ? 2'h1 : 2'h2;
					end else if (ee_busy || st_r.we || (st_r.ph == 2'h0 && st_r.cnt == pls_pkg::PROG_MAX)) begin
						st_nxt.ind = pls_pkg::IND_FAULT;
						st_nxt.st = pls_pkg::ST_HOLD;
					end else begin
						st_nxt.we = 1'b1;
						st_nxt.ea = st_r.ptr;
						st_nxt.ed = {1'b0, rx_ch};
						st_nxt.sum = st_r.sum ^ rx_ch;
						st_nxt.ptr = st_r.ptr + 15'h0001;
						st_nxt.cnt = st_r.cnt + 15'h0001;
						if (st_r.ph == 2'h1 && st_r.cnt == pls_pkg::TBL_BYTES - 15'h0001) begin
							st_nxt.ph = 2'h2;
						end
					end
				end else if (tout) begin
					st_nxt.ind = pls_pkg::IND_COMM;
					st_nxt.st = pls_pkg::ST_HOLD;
				end
			end
			pls_pkg::ST_UHDR: begin
				// Header last, so a failed upload never validates a partial image
				if (!ee_busy && !st_r.we) begin
					st_nxt.we = 1'b1;
					st_nxt.ea = pls_pkg::HDR_MODEL + st_r.cnt;
					st_nxt.cnt = st_r.cnt + 15'h0001;
					unique case (st_r.cnt[1:0])
						2'h0: st_nxt.ed = {1'b0, st_r.model};
						2'h1: st_nxt.ed = st_r.len[7:0];
						default: begin
							st_nxt.ed = {1'b0, st_r.len[AW-1:8]};
							st_nxt.ind = pls_pkg::IND_LINK;
							st_nxt.tmr = REPLY_CYC;
							st_nxt.st = pls_pkg::ST_READY;
						end
					endcase
				end
			end
			pls_pkg::ST_DHDR: begin
				if (!ee_present) begin
					st_nxt.ind = pls_pkg::IND_FAULT;
					st_nxt.st = pls_pkg::ST_HOLD;
				end else if (st_r.sub == 2'h0) begin
					st_nxt.re = 1'b1;
					st_nxt.ea = pls_pkg::HDR_MODEL + st_r.cnt;
					st_nxt.sub = 2'h1;
				end else if (st_r.sub == 2'h1) begin
					st_nxt.sub = 2'h2;
				end else begin
					st_nxt.sub = 2'h0;
					st_nxt.cnt = st_r.cnt + 15'h0001;
					if (st_r.cnt == 15'h0000) begin
						st_nxt.hmodel = ee_rdata[6:0];
					end else if (st_r.cnt == 15'h0001) begin
						st_nxt.len[7:0] = ee_rdata;
					end else begin
						st_nxt.len = hlen;
						st_nxt.st = pls_pkg::ST_HOLD;
						if (hlen == '0 || hlen > pls_pkg::PROG_MAX) begin
							st_nxt.ind = pls_pkg::IND_FAULT;
						end else if (st_r.hmodel != st_r.model) begin
							st_nxt.ind = pls_pkg::IND_MISM;
						end else begin
							st_nxt.st = pls_pkg::ST_DCMD;
						end
					end
				end
			end
			pls_pkg::ST_DCMD: begin
				if (free) begin
					st_nxt.go = 1'b1;
					st_nxt.ch = pls_pkg::CMD_DL;
					st_nxt.ptr = pls_pkg::PROG_BASE;
					st_nxt.cnt = '0;
					st_nxt.sum = '0;
					st_nxt.ph = 2'h0;
					st_nxt.sub = 2'h0;
					st_nxt.st = pls_pkg::ST_DTX;
				end
			end
			pls_pkg::ST_DTX: begin
				if (st_r.sub == 2'h0 && free) begin
					if (st_r.ph == 2'h0 && st_r.cnt == st_r.len) begin
						st_nxt.go = 1'b1;
						st_nxt.ch = pls_pkg::CH_ETX;
						st_nxt.ph = 2'h1;
						st_nxt.ptr = pls_pkg::TBL_BASE;
						st_nxt.cnt = '0;
					end else if (st_r.ph == 2'h1 && st_r.cnt == pls_pkg::TBL_BYTES) begin
						st_nxt.go = 1'b1;
						st_nxt.ch = st_r.sum;
						st_nxt.tmr = REPLY_CYC;
						st_nxt.st = pls_pkg::ST_DACK;
					end else begin
						st_nxt.re = 1'b1;
						st_nxt.ea = st_r.ptr;
						st_nxt.sub = 2'h1;
					end
				end else if (st_r.sub == 2'h1) begin
					st_nxt.sub = 2'h2;
				end else if (st_r.sub == 2'h2) begin
					st_nxt.go = 1'b1;
					st_nxt.ch = ee_rdata[6:0];
					st_nxt.sum = st_r.sum ^ ee_rdata[6:0];
					st_nxt.ptr = st_r.ptr + 15'h0001;
					st_nxt.cnt = st_r.cnt + 15'h0001;
					st_nxt.sub = 2'h0;
				end
			end
			pls_pkg::ST_DACK: begin
				if (rx_valid && !rx_perr && rx_ch == pls_pkg::CH_ACK) begin
					st_nxt.ind = pls_pkg::IND_LINK;
					st_nxt.tmr = REPLY_CYC;
					st_nxt.st = pls_pkg::ST_READY;
				end else if (rx_valid || tout) begin
					st_nxt.ind = pls_pkg::IND_COMM;
					st_nxt.st = pls_pkg::ST_HOLD;
				end
			end
			pls_pkg::ST_HOLD: begin
				if (pr != 3'b000) begin
					st_nxt.st = pls_pkg::ST_POLL;
				end
			end
			default: st_nxt.st = pls_pkg::ST_POLL;
		endcase
		// -----------------------------------------------------------
		// Lamp patterns
		// -----------------------------------------------------------
		unique case (st_nxt.ind)
			pls_pkg::IND_LINK: {st_nxt.link, st_nxt.fault} = 2'b10;
			pls_pkg::IND_BUSY: {st_nxt.link, st_nxt.fault} = {st_nxt.blk, 1'b0};
			pls_pkg::IND_COMM: {st_nxt.link, st_nxt.fault} = {1'b1, st_nxt.blk};
			pls_pkg::IND_MISM: {st_nxt.link, st_nxt.fault} = 2'b01;
			pls_pkg::IND_FAULT: {st_nxt.link, st_nxt.fault} = {1'b0, st_nxt.blk};
			default: {st_nxt.link, st_nxt.fault} = 2'b00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '{st: pls_pkg::ST_POLL, ind: pls_pkg::IND_OFF, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign link_lamp = st_r.link;
	assign fault_lamp = st_r.fault;
	assign ee_addr = st_r.ea;
	assign ee_wdata = st_r.ed;
	assign ee_we = st_r.we;
	assign ee_re = st_r.re;

endmodule : pls_loader

// [hw/pls_pkg.sv]
// Shared constants and types of the program loader and its controller end.
// Assumes a single 10 MHz clock shared by both ends.
package pls_pkg;

	// ---------------------------------------------------------------
	// Clock and serial framing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned BAUD = 9600;
	localparam int unsigned DATA_BITS = 7;
	localparam int unsigned STOP_BITS = 2;
	localparam logic [3:0] FRAME_BITS = 4'(1 + DATA_BITS + 1 + STOP_BITS);
	localparam logic [3:0] PAR_POS = 4'(DATA_BITS + 1);
	localparam logic [10:0] BIT_CYC = 11'(CLK_HZ / BAUD);
	localparam logic [10:0] HALF_CYC = 11'(CLK_HZ / BAUD / 2);

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned TMR_W = 22;
	localparam int unsigned REPLY_MS = 50;
	localparam int unsigned BLINK_MS = 250;
	localparam logic [TMR_W-1:0] REPLY_CYC = TMR_W'(REPLY_MS * (CLK_HZ / 1000));
	localparam logic [TMR_W-1:0] BLINK_CYC = TMR_W'(BLINK_MS * (CLK_HZ / 1000));

	// ---------------------------------------------------------------
	// Link characters
	// ---------------------------------------------------------------
	localparam logic [6:0] CH_ETX = 7'h03;
	localparam logic [6:0] CH_ENQ = 7'h05;
	localparam logic [6:0] CH_ACK = 7'h06;
	localparam logic [6:0] CMD_UPL = 7'h55;
	localparam logic [6:0] CMD_UPT = 7'h54;
	localparam logic [6:0] CMD_DL = 7'h44;
	// Recognised model code range; values arbitrary
	localparam logic [6:0] MODEL_FIRST = 7'h41;
	localparam logic [6:0] MODEL_LAST = 7'h47;

	// ---------------------------------------------------------------
	// EEPROM image layout (256 Kbit, byte wide)
	// ---------------------------------------------------------------
	localparam int unsigned EE_AW = 15;
	localparam logic [EE_AW-1:0] HDR_MODEL = 15'h0000;
	localparam int unsigned DATA_MEM_FIRST = 6144;
	localparam int unsigned DATA_MEM_LAST = 6655;
	localparam logic [EE_AW-1:0] TBL_BASE = 15'h0040;
	localparam logic [EE_AW-1:0] TBL_BYTES = 15'((DATA_MEM_LAST - DATA_MEM_FIRST + 1) * 2);
	localparam logic [EE_AW-1:0] PROG_BASE = 15'h0440;
	// 15.2 Kwords of program plus expansion instructions
	localparam int unsigned PROG_WORDS = 15565;
	localparam int unsigned EXP_INSTR = 18;
	localparam logic [EE_AW-1:0] PROG_MAX = 15'((PROG_WORDS + EXP_INSTR) * 2);

	// ---------------------------------------------------------------
	// Controller-end APB registers
	// ---------------------------------------------------------------
	localparam int unsigned APB_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TXD = 8'h04;
	localparam logic [7:0] REG_RXD = 8'h08;
	localparam logic [7:0] REG_STS = 8'h0c;
	localparam logic [7:0] REG_MSK = 8'h10;
	localparam int unsigned CTRL_RUN = 7;
	localparam int unsigned CTRL_SW4 = 8;
	localparam logic CTRL_RUN_RST = 1'b1;
	localparam int unsigned STS_W = 4;
	localparam int unsigned STS_RXCH = 0;
	localparam int unsigned STS_PERR = 1;
	localparam int unsigned STS_DLST = 2;
	localparam int unsigned STS_DFLT = 3;
	localparam int unsigned STS_TXBUSY = 8;

	// ---------------------------------------------------------------
	// Loader states and lamp patterns
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_POLL = 4'h0, ST_ID = 4'h1, ST_READY = 4'h3, ST_UCMD = 4'h2,
		ST_URX = 4'h6, ST_UHDR = 4'h7, ST_DHDR = 4'h5, ST_DCMD = 4'h4,
		ST_DTX = 4'hc, ST_DACK = 4'hd, ST_HOLD = 4'hf
	} pls_ldr_st_e;

	typedef enum logic [2:0] {
		IND_OFF, IND_LINK, IND_BUSY, IND_COMM, IND_MISM, IND_FAULT
	} pls_ind_e;

endpackage : pls_pkg

// [hw/pls_if.sv]
// Serial link between the loader and the controller's peripheral port.
// Assumes both ends share pclk; idle line level is high.
`timescale 1ns/10ps
interface pls_if;
	logic ldr_txd;
	logic ctl_txd;
	modport loader (output ldr_txd, input ctl_txd);
	modport ctrl (input ldr_txd, output ctl_txd);
endinterface : pls_if

// [hw/pls_uart.sv]
// Character transmitter and receiver, 7 data bits, even parity, 2 stops.
// Assumes rxd is already synchronous to pclk.
`timescale 1ns/10ps
module pls_uart (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Transmit side
	input wire logic [pls_pkg::DATA_BITS-1:0] tx_ch,
	input wire logic tx_go,
	output logic tx_busy,
	output logic txd,
	// Receive side
	input wire logic rxd,
	output logic [pls_pkg::DATA_BITS-1:0] rx_ch,
	output logic rx_valid,
	output logic rx_perr
);
	typedef struct packed {
		logic [pls_pkg::FRAME_BITS-1:0] tsh;
		logic [3:0] tbits;
		logic [10:0] ttmr;
		logic rbusy;
		logic [3:0] rbits;
		logic [10:0] rtmr;
		logic [pls_pkg::DATA_BITS:0] rsh;
		logic [pls_pkg::DATA_BITS-1:0] rdat;
		logic rval;
		logic rperr;
	} pls_uart_s;

	localparam pls_uart_s RST = '{tsh: '1, default: '0};

	pls_uart_s st_r;
	pls_uart_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.rval = 1'b0;
		if (st_r.tbits == 4'h0) begin
			if (tx_go) begin
				st_nxt.tsh = {{pls_pkg::STOP_BITS{1'b1}}, ^tx_ch, tx_ch, 1'b0};
				st_nxt.tbits = pls_pkg::FRAME_BITS;
				st_nxt.ttmr = pls_pkg::BIT_CYC - 11'h001;
			end
		end else if (st_r.ttmr == 11'h000) begin
			st_nxt.tsh = {1'b1, st_r.tsh[pls_pkg::FRAME_BITS-1:1]};
			st_nxt.tbits = st_r.tbits - 4'h1;
			st_nxt.ttmr = pls_pkg::BIT_CYC - 11'h001;
		end else begin
			st_nxt.ttmr = st_r.ttmr - 11'h001;
		end
		if (!st_r.rbusy) begin
			if (!rxd) begin
				st_nxt.rbusy = 1'b1;
				st_nxt.rbits = 4'h0;
				st_nxt.rtmr = pls_pkg::HALF_CYC;
			end
		end else if (st_r.rtmr != 11'h000) begin
			st_nxt.rtmr = st_r.rtmr - 11'h001;
		end else begin
			st_nxt.rtmr = pls_pkg::BIT_CYC - 11'h001;
			if (st_r.rbits == 4'h0) begin
				// Glitch shorter than half a bit is no start
				if (rxd) begin
					st_nxt.rbusy = 1'b0;
				end else begin
					st_nxt.rbits = 4'h1;
				end
			end else if (st_r.rbits <= pls_pkg::PAR_POS) begin
				st_nxt.rsh = {rxd, st_r.rsh[pls_pkg::DATA_BITS:1]};
				st_nxt.rbits = st_r.rbits + 4'h1;
			end else begin
				// Only the first stop bit is checked, so back-to-back frames keep up
				st_nxt.rbusy = 1'b0;
				st_nxt.rval = 1'b1;
				st_nxt.rdat = st_r.rsh[pls_pkg::DATA_BITS-1:0];
				st_nxt.rperr = (^st_r.rsh) | !rxd;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tx_busy = st_r.tbits != 4'h0;
	assign txd = st_r.tsh[0];
	assign rx_ch = st_r.rdat;
	assign rx_valid = st_r.rval;
	assign rx_perr = st_r.rperr;

endmodule : pls_uart

// [hw/pls_ctrl.sv]
// Controller end of the loader link: answers identity polls, hands other
// characters to software over APB, and reacts to a download command.
// Assumes an APB master on pclk; the loader end sits on the far side.
`timescale 1ns/10ps
module pls_ctrl (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link
	pls_if.ctrl lnk,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pls_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Status
	output logic irq,
	output logic run_mode
);
	typedef struct packed {
		logic [6:0] model;
		logic run;
		logic sw4;
		logic [6:0] rdat;
		logic [pls_pkg::STS_W-1:0] sts;
		logic [pls_pkg::STS_W-1:0] msk;
		logic go;
		logic [6:0] ch;
	} pls_ctrl_s;

	localparam pls_ctrl_s RST = '{model: pls_pkg::MODEL_FIRST,
		run: pls_pkg::CTRL_RUN_RST, default: '0};

	pls_ctrl_s st_r;
	pls_ctrl_s st_nxt;
	logic tx_busy;
	logic [6:0] rx_ch;
	logic rx_valid;
	logic rx_perr;
	logic wr;
	logic mapped;
	logic [pls_pkg::STS_W-1:0] ev;
	logic [pls_pkg::STS_W-1:0] clr;

	pls_uart u_uart (
		.pclk(pclk),
		.presetn(presetn),
		.tx_ch(st_r.ch),
		.tx_go(st_r.go),
		.tx_busy(tx_busy),
		.txd(lnk.ctl_txd),
		.rxd(lnk.ldr_txd),
		.rx_ch(rx_ch),
		.rx_valid(rx_valid),
		.rx_perr(rx_perr)
	);

	always_comb begin
		st_nxt = st_r;
		st_nxt.go = 1'b0;
		ev = '0;
		clr = '0;
		wr = psel && penable && pwrite;
		// -----------------------------------------------------------
		// Register writes
		// -----------------------------------------------------------
		if (wr) begin
			unique case (paddr)
				pls_pkg::REG_CTRL: begin
					st_nxt.model = pwdata[6:0];
					st_nxt.run = pwdata[pls_pkg::CTRL_RUN];
					st_nxt.sw4 = pwdata[pls_pkg::CTRL_SW4];
				end
				pls_pkg::REG_TXD: begin
					// Dropped while busy; software polls the busy flag
					if (!tx_busy && !st_r.go) begin
						st_nxt.go = 1'b1;
						st_nxt.ch = pwdata[6:0];
					end
				end
				pls_pkg::REG_STS: clr = pwdata[pls_pkg::STS_W-1:0];
				pls_pkg::REG_MSK: st_nxt.msk = pwdata[pls_pkg::STS_W-1:0];
				default: ;
			endcase
		end
		// -----------------------------------------------------------
		// Link events, applied after writes so hardware wins, except an ENQ reply, which yields to a TXD write
		// -----------------------------------------------------------
		if (rx_valid) begin
			if (rx_perr) begin
				ev[pls_pkg::STS_PERR] = 1'b1;
			end else if (rx_ch == pls_pkg::CH_ENQ) begin
				if (!tx_busy && !st_nxt.go && !st_r.go) begin
					st_nxt.go = 1'b1;
					st_nxt.ch = st_r.model;
				end
			end else begin
				st_nxt.rdat = rx_ch;
				ev[pls_pkg::STS_RXCH] = 1'b1;
				if (rx_ch == pls_pkg::CMD_DL) begin
					ev[pls_pkg::STS_DLST] = 1'b1;
					st_nxt.run = 1'b0;
					ev[pls_pkg::STS_DFLT] = !st_r.sw4;
				end
			end
		end
		st_nxt.sts = (st_r.sts & ~clr) | ev;
		// -----------------------------------------------------------
		// Read mux
		// -----------------------------------------------------------
		mapped = 1'b1;
		prdata = 32'h0000_0000;
		unique case (paddr)
			pls_pkg::REG_CTRL: begin
				prdata[6:0] = st_r.model;
				prdata[pls_pkg::CTRL_RUN] = st_r.run;
				prdata[pls_pkg::CTRL_SW4] = st_r.sw4;
			end
			pls_pkg::REG_TXD: ;
			pls_pkg::REG_RXD: prdata[6:0] = st_r.rdat;
			pls_pkg::REG_STS: begin
				prdata[pls_pkg::STS_W-1:0] = st_r.sts;
				prdata[pls_pkg::STS_TXBUSY] = tx_busy || st_r.go;
			end
			pls_pkg::REG_MSK: prdata[pls_pkg::STS_W-1:0] = st_r.msk;
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign irq = |(st_r.sts & st_r.msk);
	assign run_mode = st_r.run;

endmodule : pls_ctrl

// [tb/pls_sva.sv]
// Link checker: idle level and bit timing of both serial lines.
// Assumes it sits beside the link interface in tb_top.
`timescale 1ns/10ps
module pls_sva (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Serial lines
	input wire logic ldr_txd,
	input wire logic ctl_txd
);
	localparam int BIT = pls_pkg::BIT_CYC;
	logic [15:0] ldr_low_r;
	logic [15:0] ctl_low_r;
	logic [15:0] ldr_high_r;
	logic [15:0] ctl_high_r;
	logic ldr_seen_r;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Low runs only ever span whole bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ldr_low_r <= 16'h0000;
			ctl_low_r <= 16'h0000;
			// Saturated: reset counts as a long idle
			ldr_high_r <= 16'hffff;
			ctl_high_r <= 16'hffff;
			ldr_seen_r <= 1'b0;
		end else begin
			ldr_low_r <= ldr_txd ? 16'h0000 : ldr_low_r + 16'h0001;
			ctl_low_r <= ctl_txd ? 16'h0000 : ctl_low_r + 16'h0001;
			ldr_high_r <= !ldr_txd ? 16'h0000 : (&ldr_high_r ? ldr_high_r : ldr_high_r + 16'h0001);
			ctl_high_r <= !ctl_txd ? 16'h0000 : (&ctl_high_r ? ctl_high_r : ctl_high_r + 16'h0001);
			ldr_seen_r <= ldr_seen_r | !ldr_txd;
		end
	end
	a_ldr_bit_time: assert property ($rose(ldr_txd) |-> ldr_low_r % BIT == 0 && ldr_low_r <= 9 * BIT)
		else $error("loader line low run not whole bits");
	a_ctl_bit_time: assert property ($rose(ctl_txd) |-> ctl_low_r % BIT == 0 && ctl_low_r <= 9 * BIT)
		else $error("controller line low run not whole bits");
	a_idle_after_reset: assert property ($rose(presetn) |-> ldr_txd && ctl_txd)
		else $error("serial line not idle high after reset");
	a_ldr_high_run: assert property ($fell(ldr_txd) |-> ldr_high_r >= BIT)
		else $error("loader line high run shorter than a bit");
	a_ctl_high_run: assert property ($fell(ctl_txd) |-> ctl_high_r >= BIT)
		else $error("controller line high run shorter than a bit");
	a_ctl_after_ldr: assert property ($fell(ctl_txd) |-> ldr_seen_r)
		else $error("controller line active before loader spoke");
endmodule : pls_sva

// [tb/tb_top.sv]
// Bench: loader and controller ends on one link, driven by buttons and APB.
// Assumes the hw files and the link checker are compiled first.
`timescale 1ns/10ps
module tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, run_mode, prv;
	logic btn_p, btn_t, btn_r, link_lamp, fault_lamp, ee_busy, ee_we, ee_re, ee_present;
	logic [7:0] paddr, ee_rdata, lfsr, ee_prog, ee_wdata;
	logic [31:0] pwdata, prdata;
	logic [14:0] ee_addr;
	logic [6:0] ch;
	logic [32:0] exp_q[$];
	int fails, checked, tbl_wr, flips;
	pls_if lnk ();
	pls_loader #(.REPLY_CYC(22'd30000), .BLINK_CYC(22'd64)) i_pls_loader (.pclk(pclk),
		.presetn(presetn), .lnk(lnk.loader), .program_only_copy_button(btn_p),
		.program_and_table_copy_button(btn_t), .restore_to_controller_button(btn_r),
		.link_lamp(link_lamp), .fault_lamp(fault_lamp), .ee_present(ee_present), .ee_busy(ee_busy),
		.ee_rdata(ee_rdata), .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_we(ee_we), .ee_re(ee_re));
	pls_ctrl i_pls_ctrl (.pclk(pclk), .presetn(presetn), .lnk(lnk.ctrl), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .run_mode(run_mode));
	pls_sva i_pls_sva (.pclk(pclk), .presetn(presetn), .ldr_txd(lnk.ldr_txd),
		.ctl_txd(lnk.ctl_txd));
	function automatic logic [7:0] nxt(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : nxt
	task automatic chk(input logic [32:0] e, input logic [32:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wrap_up;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// Frames take ~11.5k cycles; the whole run needs about 70k
	initial begin
		repeat (95000) @(posedge pclk);
		fails++;
		wrap_up();
	end
	// EEPROM stand-in and read-data monitor
	always @(posedge pclk) begin
		if (!presetn) begin
			lfsr <= 8'h5d;
			ee_rdata <= 8'h00;
			ee_busy <= 1'b0;
			ee_prog <= 8'h00;
		end else begin
			lfsr <= nxt(lfsr);
			ee_rdata <= lfsr;
			ee_busy <= ee_we;
			if (ee_we === 1'b1 && ee_addr == 15'h0440) ee_prog <= ee_wdata;
			if (ee_we === 1'b1 && ee_addr >= 15'h0040 && ee_addr < 15'h0440) tbl_wr++;
			if (psel && penable && pready && !pwrite) chk(exp_q.pop_front(), {pslverr, prdata});
		end
	end
	// ----
	// Main sequence
	// ----
	initial begin
		{presetn, psel, penable, pwrite, btn_p, btn_t, btn_r, ee_present} = 8'h01;
		{paddr, pwdata} = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		chk(33'h0, {31'h0, link_lamp, fault_lamp});
		exp_q.push_back(33'h0c1);
		apb(1'b0, 8'h00, 32'h0);
		exp_q.push_back(33'h1_0000_0000);
		apb(1'b0, 8'h20, 32'h0);
		apb(1'b1, 8'h10, 32'h1);
		for (int i = 0; i < 40000 && link_lamp !== 1'b1; i++) @(posedge pclk);
		chk(33'h2, {31'h0, link_lamp, fault_lamp});
		btn_p <= 1'b1;
		repeat (3) @(posedge pclk);
		btn_p <= 1'b0;
		for (int i = 0; i < 20000 && irq !== 1'b1; i++) @(posedge pclk);
		exp_q.push_back(33'h55);
		apb(1'b0, 8'h08, 32'h0);
		apb(1'b1, 8'h0c, 32'h1);
		btn_t <= 1'b1;
		flips = 0;
		for (int i = 0; i < 300; i++) begin
			prv = link_lamp;
			@(posedge pclk);
			btn_t <= 1'b0;
			if (link_lamp !== prv) flips++;
		end
		chk(33'h1, {31'h0, fault_lamp, 1'(flips > 1)});
		ch = {1'b1, lfsr[5:0]};
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, 8'h04, {25'h0, k == 1 ? 7'h03 : ch});
			repeat (11460) @(posedge pclk);
		end
		chk(33'h0, {32'h0, irq});
		repeat (500) @(posedge pclk);
		chk(33'h2, {31'h0, link_lamp, fault_lamp});
		chk({26'h0, ch}, {25'h0, ee_prog});
		chk(33'h0, 33'(tbl_wr));
		chk(33'h1, {32'h0, run_mode});
		// Restore with the socket empty must end in the blinking fault state
		ee_present <= 1'b0;
		btn_r <= 1'b1;
		flips = 0;
		for (int i = 0; i < 300; i++) begin
			prv = fault_lamp;
			@(posedge pclk);
			btn_r <= 1'b0;
			if (fault_lamp !== prv) flips++;
		end
		chk(33'h1, {31'h0, link_lamp, 1'(flips > 1)});
		exp_q.push_back(33'h0c1);
		apb(1'b0, 8'h00, 32'h0);
		repeat (2) @(posedge pclk);
		wrap_up();
	end
endmodule : tb_top
